// ==== hw/fqc_counter.sv ====
`timescale 1ns/1ps
`include "fqc_defs.svh"
// How it works
// - Each channel takes a 23-bit cycle length in microseconds.
// - Each input passes a debounce filter whose length is set per channel.
// - Writing control bit 8 starts cyclic measurement on that channel.
// - Each cycle reports edges counted from the previous cycle's last edge to this cycle's last.
// - The span from the edge before the first counted edge to the last counted edge is reported in 125 ns ticks on 27 bits.
// - A cycle with no rising edge reports the maximum period.
// - Period zero with count zero means the cycle was too short for a second edge.
// - A new cycle length applies only from the next cycle.
// - Writing control bit 9 stops measurement on that channel.
// - Stopping mid-cycle reports period 0x7fffffff and count zero.
// - Each channel holds its own cycle length and control word.
module fqc_counter #(
	parameter int NCH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pulse inputs from pins
	input wire logic [NCH-1:0] pulse_in,
	// Measurement active flags
	output logic [NCH-1:0] meas_active
);
	import fqc_pkg::*;

	typedef struct packed {
		logic [NCH-1:0][1:0] sync;
		logic [NCH-1:0] filt;
		logic [NCH-1:0] filt_prev;
		logic [NCH-1:0][3:0] fcnt;
		fqc_flt_t [NCH-1:0] flt_len;
		logic [2:0] ptick_cnt;
		logic [5:0] utick_cnt;
		logic [NCH-1:0][`FQC_CYC_W-1:0] cyc_len;
		logic [NCH-1:0][`FQC_CYC_W-1:0] cyc_cur;
		logic [NCH-1:0][`FQC_CYC_W-1:0] cyc_cnt;
		fqc_mode_e [NCH-1:0] mode;
		logic [NCH-1:0][`FQC_PER_W-1:0] tmr;
		logic [NCH-1:0][`FQC_PER_W-1:0] span;
		logic [NCH-1:0][31:0] edges;
		logic [NCH-1:0] seen;
		logic [NCH-1:0] hit;
		logic [NCH-1:0][31:0] per_out;
		logic [NCH-1:0][31:0] edg_out;
		logic [NCH-1:0][9:8] ctl;
		logic dph;
		logic dwr;
		logic [11:0] daddr;
		logic [31:0] rdata;
	} fqc_state_s;

	fqc_state_s s_q;
	fqc_state_s s_d;
	logic ptick;
	logic utick;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] cyc_end;
	logic [NCH-1:0] start_req;
	logic [NCH-1:0] stop_req;
	logic aph;

	// Address phase accepted
	assign aph = hsel && hready && htrans[1];

	// Tick strobes and filtered rising edges
	assign ptick = (s_q.ptick_cnt == 3'(`FQC_PER_DIV - 1));
	assign utick = (s_q.utick_cnt == 6'(`FQC_CYC_DIV - 1));
	assign rise = s_q.filt & ~s_q.filt_prev;

	// Control writes decoded per channel
	always_comb begin
		start_req = '0;
		stop_req = '0;
		if (s_q.dph && s_q.dwr && s_q.daddr == `FQC_OFF_CTL0) begin
			start_req[0] = hwdata[`FQC_CTL_START];
			stop_req[0] = hwdata[`FQC_CTL_STOP];
		end
		if (NCH > 1 && s_q.dph && s_q.dwr && s_q.daddr == `FQC_OFF_CTL1) begin
			start_req[NCH-1] = hwdata[`FQC_CTL_START];
			stop_req[NCH-1] = hwdata[`FQC_CTL_STOP];
		end
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.ptick_cnt = ptick ? 3'h0 : s_q.ptick_cnt + 3'h1;
		s_d.utick_cnt = utick ? 6'h00 : s_q.utick_cnt + 6'h01;
		s_d.filt_prev = s_q.filt;
		cyc_end = '0;
		for (int c = 0; c < NCH; c++) begin
			// Two-flop synchroniser, only second stage read
			s_d.sync[c] = {s_q.sync[c][0], pulse_in[c]};
			// filter needs a stable level for flt_len + 1 ticks of 125 ns
			if (s_q.sync[c][1] == s_q.filt[c]) begin
				s_d.fcnt[c] = 4'h0;
			end else if (ptick) begin
				if (s_q.fcnt[c] >= s_q.flt_len[c]) begin
					s_d.filt[c] = s_q.sync[c][1];
					s_d.fcnt[c] = 4'h0;
				end else begin
					s_d.fcnt[c] = s_q.fcnt[c] + 4'h1;
				end
			end
			case (s_q.mode[c])
				FQC_IDLE: begin
					if (start_req[c] && !stop_req[c]) begin
						s_d.mode[c] = FQC_RUN;
						s_d.cyc_cur[c] = s_q.cyc_len[c];
						s_d.cyc_cnt[c] = '0;
						s_d.edges[c] = '0;
						s_d.seen[c] = 1'b0;
						s_d.hit[c] = 1'b0;
						s_d.tmr[c] = '0;
						s_d.span[c] = '0;
					end
				end
				FQC_RUN: begin
					// period timer in 125 ns ticks, saturating
					if (ptick && s_q.tmr[c] != `FQC_PER_MAX) begin
						s_d.tmr[c] = s_q.tmr[c] + 27'h1;
					end
					// each edge after the first closes the span from the edge that opened it
					if (rise[c]) begin
						s_d.seen[c] = 1'b1;
						s_d.hit[c] = 1'b1;
						if (s_q.seen[c]) begin
							s_d.span[c] = s_q.tmr[c];
							s_d.edges[c] = s_q.edges[c] + 32'h1;
						end else begin
							// First edge opens the span; its own tick is kept
							s_d.tmr[c] = {26'h0, ptick};
						end
					end
					if (utick) begin
						s_d.cyc_cnt[c] = s_q.cyc_cnt[c] + 23'h1;
					end
					cyc_end[c] = utick && (s_q.cyc_cnt[c] + 23'h1 >= s_q.cyc_cur[c]);
					if (stop_req[c]) begin
						s_d.mode[c] = FQC_IDLE;
						// aborted cycle reports period 0x7fffffff and no edges
						s_d.per_out[c] = `FQC_STOP_PER;
						s_d.edg_out[c] = '0;
					end else if (cyc_end[c]) begin
						if (!s_q.hit[c] && !rise[c]) begin
							s_d.per_out[c] = 32'(`FQC_PER_MAX);
							s_d.edg_out[c] = '0;
						end else begin
							// zero span and zero count mean too short
							s_d.per_out[c] = 32'(s_d.span[c]);
							s_d.edg_out[c] = s_d.edges[c];
						end
						// next cycle picks up the new length
						s_d.cyc_cur[c] = s_q.cyc_len[c];
						s_d.cyc_cnt[c] = '0;
						s_d.edges[c] = '0;
						s_d.hit[c] = 1'b0;
						// Last edge of this cycle starts the next span
						s_d.tmr[c] = s_d.tmr[c] - s_d.span[c];
						s_d.span[c] = '0;
					end
				end
				default: s_d.mode[c] = FQC_IDLE;
			endcase
		end
		// Bus data phase
		s_d.dph = aph;
		s_d.dwr = aph && hwrite;
		s_d.daddr = aph ? haddr[11:0] : s_q.daddr;
		if (s_q.dph && s_q.dwr) begin
			case (s_q.daddr)
				// separate length and control per channel
				`FQC_OFF_CYC0: s_d.cyc_len[0] = hwdata[`FQC_CYC_W-1:0];
				`FQC_OFF_CYC1: s_d.cyc_len[NCH-1] = hwdata[`FQC_CYC_W-1:0];
				`FQC_OFF_CTL0: s_d.ctl[0] = hwdata[9:8];
				`FQC_OFF_CTL1: s_d.ctl[NCH-1] = hwdata[9:8];
				`FQC_OFF_FLT: begin
					s_d.flt_len[0] = hwdata[3:0];
					s_d.flt_len[NCH-1] = hwdata[11:8];
				end
				default: ;
			endcase
		end
		// Read data registered at address phase
		s_d.rdata = 32'h0;
		if (aph && !hwrite) begin
			case (haddr[11:0])
				`FQC_OFF_CYC0: s_d.rdata = 32'(s_q.cyc_len[0]);
				`FQC_OFF_CYC1: s_d.rdata = 32'(s_q.cyc_len[NCH-1]);
				`FQC_OFF_CTL0: s_d.rdata = {22'h0, s_q.ctl[0], 8'h00};
				`FQC_OFF_CTL1: s_d.rdata = {22'h0, s_q.ctl[NCH-1], 8'h00};
				`FQC_OFF_PER0: s_d.rdata = s_q.per_out[0];
				`FQC_OFF_EDG0: s_d.rdata = s_q.edg_out[0];
				`FQC_OFF_PER1: s_d.rdata = s_q.per_out[NCH-1];
				`FQC_OFF_EDG1: s_d.rdata = s_q.edg_out[NCH-1];
				`FQC_OFF_STA: s_d.rdata = {30'h0, s_q.mode[NCH-1] == FQC_RUN, s_q.mode[0] == FQC_RUN};
				`FQC_OFF_FLT: s_d.rdata = {20'h0, s_q.flt_len[NCH-1], 4'h0, s_q.flt_len[0]};
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	// State register, synchronous reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
			for (int c = 0; c < NCH; c++) begin
				s_q.mode[c] <= FQC_IDLE;
				s_q.cyc_len[c] <= `FQC_CYC_RST;
				s_q.cyc_cur[c] <= `FQC_CYC_RST;
			end
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_act
			assign meas_active[g] = (s_q.mode[g] == FQC_RUN);
		end
	endgenerate

	// Checks
	AST_START: assert property (@(posedge clk) disable iff (sys_rst)
		(start_req[0] && !stop_req[0] && s_q.mode[0] == FQC_IDLE) |=> meas_active[0])
		else $error("start did not activate channel 0");
	AST_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_req[0] && meas_active[0]) |=> !meas_active[0])
		else $error("stop did not end channel 0");
	AST_ABORT: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_req[0] && meas_active[0]) |=> (s_q.per_out[0] == 32'h7fffffff && s_q.edg_out[0] == 32'h0))
		else $error("abort result wrong");
	AST_NOEDGE: assert property (@(posedge clk) disable iff (sys_rst)
		(cyc_end[0] && !stop_req[0] && !s_q.hit[0] && !rise[0]) |=> s_q.per_out[0] == 32'h07ffffff)
		else $error("empty cycle not max period");
	AST_PTICK: assert property (@(posedge clk) disable iff (sys_rst)
		ptick |=> !ptick [*4] ##1 ptick)
		else $error("125 ns tick spacing wrong");
	AST_RDZERO: assert property (@(posedge clk) disable iff (sys_rst)
		(aph && !hwrite && haddr[11:0] == 12'h00c) |=> hrdata[31:10] == 22'h0)
		else $error("reserved control bits not zero");
	AST_CYCLEN: assert property (@(posedge clk) disable iff (sys_rst)
		(meas_active[0] && !cyc_end[0] && !stop_req[0]) |=> $stable(s_q.cyc_cur[0]))
		else $error("cycle length changed mid-cycle");
	AST_SPAN: assert property (@(posedge clk) disable iff (sys_rst)
		(cyc_end[0] && !stop_req[0] && (s_q.hit[0] || rise[0])) |=> s_q.per_out[0][31:27] == 5'h0)
		else $error("period wider than 27 bits");
	AST_START1: assert property (@(posedge clk) disable iff (sys_rst)
		(start_req[NCH-1] && !stop_req[NCH-1] && s_q.mode[NCH-1] == FQC_IDLE) |=> meas_active[NCH-1])
		else $error("start did not activate last channel");
	AST_STOP1: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_req[NCH-1] && meas_active[NCH-1]) |=> !meas_active[NCH-1])
		else $error("stop did not end last channel");
	AST_ABORT1: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_req[NCH-1] && meas_active[NCH-1])
		|=> (s_q.per_out[NCH-1] == 32'h7fffffff && s_q.edg_out[NCH-1] == 32'h0))
		else $error("abort result wrong on last channel");
	AST_NOEDGE1: assert property (@(posedge clk) disable iff (sys_rst)
		(cyc_end[NCH-1] && !stop_req[NCH-1] && !s_q.hit[NCH-1] && !rise[NCH-1])
		|=> s_q.per_out[NCH-1] == 32'h07ffffff)
		else $error("empty cycle not max period on last channel");
	AST_UTICK: assert property (@(posedge clk) disable iff (sys_rst)
		utick |=> !utick ##39 utick)
		else $error("1 us tick spacing wrong");
	AST_EDGES: assert property (@(posedge clk) disable iff (sys_rst)
		(meas_active[0] && rise[0] && s_q.seen[0] && !cyc_end[0] && !stop_req[0])
		|=> s_q.edges[0] == $past(s_q.edges[0]) + 32'h1)
		else $error("counted edge not added");
	AST_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
		(meas_active[0] && rise[0] && !s_q.seen[0] && !stop_req[0]) |=> (s_q.span[0] == 27'h0 && s_q.edges[0] == 32'h0))
		else $error("first edge did not open an empty span");
	AST_FILT: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.sync[0][1] == s_q.filt[0]) |=> $stable(s_q.filt[0]))
		else $error("filter moved without input change");
	AST_RDMAP: assert property (@(posedge clk) disable iff (sys_rst)
		(aph && !hwrite && haddr[11:0] > 12'h024) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
		(!meas_active[0] && !(start_req[0] && !stop_req[0])) |=> !meas_active[0])
		else $error("channel 0 active without start");
	AST_CYCEND: assert property (@(posedge clk) disable iff (sys_rst)
		(meas_active[0] && cyc_end[0] && !stop_req[0]) |=> s_q.cyc_cur[0] == $past(s_q.cyc_len[0]))
		else $error("new cycle length not taken at cycle end");
	AST_RDLEN: assert property (@(posedge clk) disable iff (sys_rst)
		(aph && !hwrite && haddr[11:0] == 12'h000) |=> hrdata[31:23] == 9'h0)
		else $error("cycle length wider than 23 bits");
endmodule // fqc_counter

// ==== hw/fqc_defs.svh ====
`ifndef FQC_DEFS_SVH
`define FQC_DEFS_SVH
// Register byte offsets (one word each)
`define FQC_OFF_CYC0 12'h000
`define FQC_OFF_CYC1 12'h004
`define FQC_OFF_CTL0 12'h008
`define FQC_OFF_CTL1 12'h00c
`define FQC_OFF_PER0 12'h010
`define FQC_OFF_EDG0 12'h014
`define FQC_OFF_PER1 12'h018
`define FQC_OFF_EDG1 12'h01c
`define FQC_OFF_STA 12'h020
`define FQC_OFF_FLT 12'h024
// Control word fields
`define FQC_CTL_START 8
`define FQC_CTL_STOP 9
// Field widths and reset values
`define FQC_CYC_W 23
`define FQC_PER_W 27
`define FQC_PER_MAX 27'h7ffffff
`define FQC_STOP_PER 32'h7fffffff
`define FQC_CYC_RST 23'h0003e8
// Timing: clock period and tick lengths in ns
`define FQC_CLK_NS 25
`define FQC_PER_TICK_NS 125
`define FQC_CYC_TICK_NS 1000
`define FQC_PER_DIV (`FQC_PER_TICK_NS / `FQC_CLK_NS)
`define FQC_CYC_DIV (`FQC_CYC_TICK_NS / `FQC_CLK_NS)
`endif

// ==== hw/fqc_pkg.sv ====
package fqc_pkg;
	typedef enum logic [1:0] {
		FQC_IDLE = 2'b01,
		FQC_RUN = 2'b10
	} fqc_mode_e;
	typedef logic [3:0] fqc_flt_t;
endpackage

// ==== test/fqc_pulse_src.sv ====
`timescale 1ns/1ps
// Pulse source standing in for the field signal, square wave of settable half period
module fqc_pulse_src (
	// Clock and control
	input wire logic clk,
	input wire logic en,
	input wire logic signed [31:0] half_clks,
	// Field signal
	output logic pulse
);
	int cnt = 0;
	initial pulse = 1'b0;
	// edge source
	// Held low while disabled so a cycle with no edge can be set up on purpose
	always @(posedge clk) begin
		if (!en) begin
			cnt <= 0;
			pulse <= 1'b0;
		end else if (cnt >= half_clks - 1) begin
			cnt <= 0;
			pulse <= ~pulse;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // fqc_pulse_src

// ==== test/tb_fqc_counter.sv ====
`timescale 1ns/1ps
`include "fqc_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb_fqc_counter;
	import fqc_pkg::*;
	logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, rd_pend = 0, hreadyout, hresp;
	logic [1:0] htrans = 2'b00, meas_active, src_en = 2'b00;
	// One source per bit, so a net rather than a variable
	wire [1:0] pulse_in;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'hd1e2;
	logic [31:0] exp_q[$], exp_v;
	int errors = 0, n_tests = 0, per_us[2], half[2];
	fqc_counter fqc_counter_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pulse_in(pulse_in), .meas_active(meas_active));
	fqc_pulse_src src0_i (.clk(clk), .en(src_en[0]), .half_clks(half[0]), .pulse(pulse_in[0]));
	fqc_pulse_src src1_i (.clk(clk), .en(src_en[1]), .half_clks(half[1]), .pulse(pulse_in[1]));
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// One AHB-Lite single word transfer; read data noted for the monitor
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1; htrans <= 2'b10; haddr <= {20'h0, a}; hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= w ? d : 32'h0;
		if (!w) exp_q.push_back(d);
		rd_pend <= ~w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_pend <= 1'b0;
	endtask
	// Compare read data at the end of each read data phase
	always @(posedge clk) begin
		if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0) begin
			// Pop once; the macro reads its arguments twice
			exp_v = exp_q.pop_front();
			`CHK(hrdata, exp_v)
			`CHK(hresp, 1'b0)
		end
	end
	task automatic wait_us(input int n);
		repeat (n * 40) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog against a hung transfer
	initial begin
		#500us;
		errors++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		ahb(0, `FQC_OFF_CYC0, 32'h3e8);
		ahb(0, `FQC_OFF_CYC1, 32'h3e8);
		ahb(0, `FQC_OFF_CTL0, 32'h0);
		ahb(0, `FQC_OFF_STA, 32'h0);
		ahb(0, 12'h030, 32'h0);
		ahb(1, `FQC_OFF_CYC0, 32'hffffffff);
		ahb(0, `FQC_OFF_CYC0, 32'h7fffff);
		// per-channel filter setting, short enough for a 500 ns half period
		ahb(1, `FQC_OFF_FLT, 32'h0201);
		ahb(0, `FQC_OFF_FLT, 32'h0201);
		$display("test registers done");
		// cycle of 10 us, long enough for any chosen pulse period
		ahb(1, `FQC_OFF_CYC0, 32'd10);
		ahb(1, `FQC_OFF_CYC1, 32'd10);
		ahb(1, `FQC_OFF_CTL0, 32'h100);
		ahb(1, `FQC_OFF_CTL1, 32'h100);
		repeat (2) @(posedge clk);
		`CHK(meas_active, 2'b11)
		wait_us(25);
		ahb(0, `FQC_OFF_PER0, {5'h0, `FQC_PER_MAX});
		ahb(0, `FQC_OFF_EDG1, 32'h0);
		$display("test no edge done");
		// Random pulse periods dividing the cycle: span is whole cycle
		for (int c = 0; c < 2; c++) begin
			seed = xs(seed);
			per_us[c] = (seed % 3 == 0) ? 1 : (seed % 3 == 1) ? 2 : 5;
			half[c] = per_us[c] * 20;
		end
		src_en <= 2'b11;
		wait_us(40);
		ahb(0, `FQC_OFF_PER0, 32'd80);
		ahb(0, `FQC_OFF_EDG0, 32'(10 / per_us[0]));
		ahb(0, `FQC_OFF_PER1, 32'd80);
		ahb(0, `FQC_OFF_EDG1, 32'(10 / per_us[1]));
		$display("test counting done");
		// new length applies from a later cycle
		ahb(1, `FQC_OFF_CYC0, 32'd20);
		wait_us(50);
		ahb(0, `FQC_OFF_PER0, 32'd160);
		ahb(0, `FQC_OFF_EDG0, 32'(20 / per_us[0]));
		$display("test length change done");
		// Stop mid-cycle; start and stop together on channel 1
		wait_us(3);
		ahb(1, `FQC_OFF_CTL0, 32'h200);
		ahb(1, `FQC_OFF_CTL1, 32'h300);
		repeat (2) @(posedge clk);
		`CHK(meas_active, 2'b00)
		ahb(0, `FQC_OFF_PER0, `FQC_STOP_PER);
		ahb(0, `FQC_OFF_EDG0, 32'h0);
		ahb(0, `FQC_OFF_PER1, `FQC_STOP_PER);
		ahb(0, `FQC_OFF_STA, 32'h0);
		$display("test stop done");
		finish_test();
	end
endmodule // tb_fqc_counter
